// *** chan_fifo_pkg.sv ***
// constants, register map and capacity helpers for the channel fifo manager
// Function
// (RULE1) one data address: write fills tx, read drains rx
// (RULE2) separate tx and rx fifo reset bits
// (RULE3) four flags per fifo readable in csr
// (RULE4) all flags active low, zero means true
// (RULE5) empty when none stored, full at capacity
// (RULE6) almost empty while count at or below threshold
// (RULE7) almost full while count reaches size minus threshold
// (RULE8) both almost thresholds reset to seven
// (RULE9) new thresholds act at once; change while empty
// (RULE10) no programming sequence or settling delay
// (RULE11) fifo capacity detected after every board reset
// (RULE12) live occupancy counter per fifo
// (RULE13) two-bit field assigns larger memory to rx or tx
// (RULE14) depth option is a build parameter
// (RULE15) board reset restores registers and empties fifos
// (RULE16) every flag also drives an interrupt source line
// (RULE17) count register: rx upper half, tx lower half
// (RULE18) size register: rx upper half, tx lower half
// (RULE19) push with pop keeps count; overflow and underflow ignored
// (RULE20) flags derived combinationally from count, size, thresholds
package chan_fifo_pkg;

  localparam int NCH = 4;

  // register offsets inside one channel block
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_CSR = 5'h04;
  localparam logic [4:0] OFS_TX_ALMOST = 5'h08;
  localparam logic [4:0] OFS_RX_ALMOST = 5'h0c;
  localparam logic [4:0] OFS_COUNT = 5'h10;
  localparam logic [4:0] OFS_SIZE = 5'h14;
  localparam int CH_LSB = 5;
  localparam int CH_W = 2;
  localparam int BOARD_SEL_BIT = 7;
  localparam logic [7:0] BOARD_CTRL_ADR = 8'h80;
  localparam int BOARD_RESET_BIT = 0;
  localparam logic [3:0] SEL_ALL = 4'hf;

  // control/status bit positions
  localparam int CSR_TX_RST = 0;
  localparam int CSR_RX_RST = 1;
  localparam int CSR_ALLOC_LSB = 4;
  localparam int CSR_TX_FLAG_LSB = 8;
  localparam int CSR_RX_FLAG_LSB = 12;
  localparam logic [1:0] ALLOC_RX_LARGE = 2'h1;
  localparam logic [1:0] ALLOC_RST = 2'h0;

  // flag order inside a four-bit group
  localparam int FLG_EMPTY = 0;
  localparam int FLG_AEMPTY = 1;
  localparam int FLG_AFULL = 2;
  localparam int FLG_FULL = 3;

  localparam logic [31:0] ALMOST_RST = 32'h0007_0007;

  localparam logic [15:0] CAP_4K = 16'h1000;
  localparam logic [15:0] CAP_8K = 16'h2000;
  localparam logic [15:0] CAP_16K = 16'h4000;
  localparam logic [15:0] CAP_32K = 16'h8000;

  typedef enum {OPT_4K_8K, OPT_8K_16K, OPT_32K} fifo_opt_e;

  function automatic logic [15:0] small_cap(input fifo_opt_e opt);
    case (opt)
      OPT_4K_8K: small_cap = CAP_4K;
      OPT_8K_16K: small_cap = CAP_8K;
      default: small_cap = CAP_32K;
    endcase
  endfunction

  function automatic logic [15:0] large_cap(input fifo_opt_e opt);
    case (opt)
      OPT_4K_8K: large_cap = CAP_8K;
      OPT_8K_16K: large_cap = CAP_16K;
      default: large_cap = CAP_32K;
    endcase
  endfunction

endpackage

// *** reset_sync.sv ***
// two-stage release synchroniser for the board reset
module reset_sync (
  input wire logic core_clk,
  input wire logic nrst,
  output logic rst_n
);

  logic meta_q;
  logic sync_q;

  // assert at once, release after two edges to avoid metastable release
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign rst_n = sync_q;

endmodule

// *** fifo_ctrl.sv ***
// one byte fifo with occupancy counter and active-low flags
module fifo_ctrl
  import chan_fifo_pkg::*;
#(
  parameter int DEPTH = 32768
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic [7:0] wr_data,
  input wire logic [15:0] size,
  input wire logic [15:0] ae_thr,
  input wire logic [15:0] af_thr,
  output logic [7:0] head,
  output logic [15:0] count,
  output logic [3:0] flags_n,
  output logic pop_ok
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [15:0] count_q, count_d;
  logic do_push, do_pop;
  logic [16:0] af_lim;

  // RULE19 overflow and underflow dropped
  assign do_push = push && (count_q != size);
  assign do_pop = pop && (count_q != 16'h0000);
  assign pop_ok = do_pop && !clr;
  assign head = mem[rd_ptr_q];
  assign count = count_q;

  // pointers wrap at the allocated size, not at the array depth
  always_comb
  begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    if (do_push)
      wr_ptr_d = (16'(wr_ptr_q) == size - 16'h0001) ? '0 : wr_ptr_q + PTR_ONE;
    if (do_pop)
      rd_ptr_d = (16'(rd_ptr_q) == size - 16'h0001) ? '0 : rd_ptr_q + PTR_ONE;
    // RULE12 count every push and pop
    if (do_push && !do_pop)
      count_d = count_q + 16'h0001;
    else if (do_pop && !do_push)
      count_d = count_q - 16'h0001;
    // RULE2 clear empties only this fifo
    if (clr)
    begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // storage is not reset; the counter alone defines what is valid
  always_ff @(posedge core_clk)
  begin
    if (do_push && !clr)
      mem[wr_ptr_q] <= wr_data;
  end

  // RULE20 flags from count, size and thresholds
  assign af_lim = {1'b0, size} - {1'b0, af_thr};
  always_comb
  begin
    // RULE4 zero means condition true
    // RULE5 empty and full exact
    flags_n[FLG_EMPTY] = !(count_q == 16'h0000);
    flags_n[FLG_FULL] = !(count_q == size);
    // RULE6 at or below threshold
    flags_n[FLG_AEMPTY] = !(count_q <= ae_thr);
    // RULE7 at or above size minus threshold
    flags_n[FLG_AFULL] = !(af_lim[16] || ({1'b0, count_q} >= af_lim));
  end

  property p_count_up;
    @(posedge core_clk) disable iff (!rst_n)
    (push && !pop && !clr && count_q != size) |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not rise on push"); // RULE12

  property p_push_full;
    @(posedge core_clk) disable iff (!rst_n)
    (push && !pop && !clr && count_q == size) |=> $stable(count_q) && !flags_n[FLG_FULL];
  endproperty
  a_push_full: assert property (p_push_full) else $error("push to full changed count"); // RULE19

  property p_both;
    @(posedge core_clk) disable iff (!rst_n)
    (push && pop && !clr && count_q != 16'h0000 && count_q != size) |=> $stable(count_q);
  endproperty
  a_both: assert property (p_both) else $error("push with pop changed count"); // RULE19

  sequence s_last_out;
    pop && !push && !clr && count_q == 16'h0001;
  endsequence
  property p_goes_empty;
    @(posedge core_clk) disable iff (!rst_n)
    s_last_out |=> !flags_n[FLG_EMPTY] ##1 ($past(push) || !flags_n[FLG_EMPTY]);
  endproperty
  a_goes_empty: assert property (p_goes_empty) else $error("empty flag not asserted"); // RULE5

  property p_aempty;
    @(posedge core_clk) disable iff (!rst_n)
    (pop && !push && !clr && count_q == ae_thr + 16'h0001 && $stable(ae_thr))
      |=> !flags_n[FLG_AEMPTY] && $past(flags_n[FLG_AEMPTY]);
  endproperty
  a_aempty: assert property (p_aempty) else $error("almost empty missed"); // RULE6

  property p_afull;
    @(posedge core_clk) disable iff (!rst_n)
    (push && !pop && !clr && size > af_thr && count_q == size - af_thr - 16'h0001
      && $stable(af_thr)) |=> !flags_n[FLG_AFULL] && $past(flags_n[FLG_AFULL]);
  endproperty
  a_afull: assert property (p_afull) else $error("almost full missed"); // RULE7

endmodule

// *** chan_fifo_mgr.sv ***
// four-channel tx/rx fifo manager with a classic wishbone register slave
module chan_fifo_mgr
  import chan_fifo_pkg::*;
#(
  parameter fifo_opt_e FIFO_OPT = OPT_32K
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic [NCH-1:0] tx_pop,
  output logic [8*NCH-1:0] tx_data,
  output logic [NCH-1:0] tx_empty_n,
  input wire logic [NCH-1:0] rx_push,
  input wire logic [8*NCH-1:0] rx_data,
  output logic [NCH-1:0] rx_full_n,
  output logic [8*NCH-1:0] irq_src_n
);

  // RULE14 depth option fixed at build time
  localparam int DEPTH = int'(large_cap(FIFO_OPT));
  // capacities are also the reset sizes, so full never shows while in reset
  localparam logic [15:0] CAP_LARGE = large_cap(FIFO_OPT);
  localparam logic [15:0] CAP_SMALL = small_cap(FIFO_OPT);

  logic rst_n;
  logic req, wr_full;
  logic [CH_W-1:0] ch;
  logic [4:0] ofs;

  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic brd_clr_q, brd_clr_d;
  logic done_q, done_d;
  logic [1:0] alloc_q [NCH];
  logic [1:0] alloc_d [NCH];
  logic [31:0] tx_alm_q [NCH];
  logic [31:0] tx_alm_d [NCH];
  logic [31:0] rx_alm_q [NCH];
  logic [31:0] rx_alm_d [NCH];
  logic [15:0] tx_size_q [NCH];
  logic [15:0] tx_size_d [NCH];
  logic [15:0] rx_size_q [NCH];
  logic [15:0] rx_size_d [NCH];
  logic [7:0] tx_data_q [NCH];
  logic [7:0] tx_data_d [NCH];

  logic [NCH-1:0] host_push, host_pop, tx_clr, rx_clr, tx_pop_ok, rx_pop_ok;
  logic [7:0] rx_head [NCH];
  logic [7:0] tx_head [NCH];
  logic [15:0] tx_cnt [NCH];
  logic [15:0] rx_cnt [NCH];
  logic [3:0] tx_flg [NCH];
  logic [3:0] rx_flg [NCH];

  reset_sync u_rst (
    .core_clk(core_clk),
    .nrst(nrst),
    .rst_n(rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fifo pairs

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      fifo_ctrl #(.DEPTH(DEPTH)) u_tx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clr(tx_clr[g]),
        .push(host_push[g]),
        .pop(tx_pop[g]),
        .wr_data(wb_dat_w[7:0]),
        .size(tx_size_q[g]),
        .ae_thr(tx_alm_q[g][15:0]),
        .af_thr(tx_alm_q[g][31:16]),
        .head(tx_head[g]),
        .count(tx_cnt[g]),
        .flags_n(tx_flg[g]),
        .pop_ok(tx_pop_ok[g])
      );
      fifo_ctrl #(.DEPTH(DEPTH)) u_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clr(rx_clr[g]),
        .push(rx_push[g]),
        .pop(host_pop[g]),
        .wr_data(rx_data[8*g +: 8]),
        .size(rx_size_q[g]),
        .ae_thr(rx_alm_q[g][15:0]),
        .af_thr(rx_alm_q[g][31:16]),
        .head(rx_head[g]),
        .count(rx_cnt[g]),
        .flags_n(rx_flg[g]),
        .pop_ok(rx_pop_ok[g])
      );
      assign tx_data[8*g +: 8] = tx_data_q[g];
      assign tx_empty_n[g] = tx_flg[g][FLG_EMPTY];
      assign rx_full_n[g] = rx_flg[g][FLG_FULL];
      // RULE16 flags exported per channel as interrupt sources
      assign irq_src_n[8*g +: 8] = {rx_flg[g], tx_flg[g]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // one access per request: ack_q blocks a second take in the ack cycle
  assign req = wb_cyc && wb_stb && !ack_q;
  assign wr_full = wb_we && (wb_sel == SEL_ALL);
  assign ch = wb_adr[CH_LSB +: CH_W];
  assign ofs = wb_adr[4:0];
  assign wb_ack = ack_q;
  assign wb_dat_r = rdat_q;

  // RULE1 shared data address per channel
  always_comb
  begin
    host_push = '0;
    host_pop = '0;
    if (req && !wb_adr[BOARD_SEL_BIT] && ofs == OFS_DATA)
    begin
      host_push[ch] = wb_we && wb_sel[0];
      host_pop[ch] = !wb_we;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and read mux

  always_comb
  begin
    ack_d = req;
    rdat_d = rdat_q;
    brd_clr_d = 1'b0;
    done_d = 1'b1;
    tx_clr = '0;
    rx_clr = '0;
    alloc_d = alloc_q;
    tx_alm_d = tx_alm_q;
    rx_alm_d = rx_alm_q;
    tx_size_d = tx_size_q;
    rx_size_d = rx_size_q;
    tx_data_d = tx_data_q;
    for (int c = 0; c < NCH; c++)
    begin
      if (tx_pop_ok[c])
        tx_data_d[c] = tx_head[c];
    end
    if (req)
    begin
      rdat_d = '0;
      if (wb_adr == BOARD_CTRL_ADR)
      begin
        if (wr_full)
          brd_clr_d = wb_dat_w[BOARD_RESET_BIT];
      end
      else if (!wb_adr[BOARD_SEL_BIT])
      begin
        case (ofs)
          OFS_DATA:
            rdat_d[7:0] = rx_pop_ok[ch] ? rx_head[ch] : 8'h00;
          OFS_CSR:
          begin
            // RULE3 flags readable any time
            rdat_d[CSR_ALLOC_LSB +: 2] = alloc_q[ch];
            rdat_d[CSR_TX_FLAG_LSB +: 4] = tx_flg[ch];
            rdat_d[CSR_RX_FLAG_LSB +: 4] = rx_flg[ch];
            if (wr_full)
            begin
              // RULE2 per-fifo reset bits
              tx_clr[ch] = wb_dat_w[CSR_TX_RST];
              rx_clr[ch] = wb_dat_w[CSR_RX_RST];
              // RULE13 allocation choice, fifos restart empty on change
              alloc_d[ch] = wb_dat_w[CSR_ALLOC_LSB +: 2];
              if (alloc_d[ch] != alloc_q[ch])
              begin
                tx_clr[ch] = 1'b1;
                rx_clr[ch] = 1'b1;
              end
            end
          end
          OFS_TX_ALMOST:
          begin
            rdat_d = tx_alm_q[ch];
            // RULE9 threshold acts at once
            // RULE10 no sequence or delay
            if (wr_full)
              tx_alm_d[ch] = wb_dat_w;
          end
          OFS_RX_ALMOST:
          begin
            rdat_d = rx_alm_q[ch];
            if (wr_full)
              rx_alm_d[ch] = wb_dat_w;
          end
          // RULE17 rx count high, tx count low
          OFS_COUNT: rdat_d = {rx_cnt[ch], tx_cnt[ch]};
          // RULE18 rx size high, tx size low
          OFS_SIZE: rdat_d = {rx_size_q[ch], tx_size_q[ch]};
          default: rdat_d = '0;
        endcase
      end
    end
    // RULE11 capacity detected after reset or allocation change
    for (int c = 0; c < NCH; c++)
    begin
      if (!done_q || alloc_d[c] != alloc_q[c])
      begin
        tx_size_d[c] = (alloc_d[c] == ALLOC_RX_LARGE) ? small_cap(FIFO_OPT)
                                                       : large_cap(FIFO_OPT);
        rx_size_d[c] = (alloc_d[c] == ALLOC_RX_LARGE) ? large_cap(FIFO_OPT)
                                                       : small_cap(FIFO_OPT);
      end
    end
    // RULE15 board reset restores defaults and empties every fifo
    if (brd_clr_q)
    begin
      done_d = 1'b0;
      tx_clr = '1;
      rx_clr = '1;
      for (int c = 0; c < NCH; c++)
      begin
        alloc_d[c] = ALLOC_RST;
        tx_alm_d[c] = ALMOST_RST;
        rx_alm_d[c] = ALMOST_RST;
        tx_data_d[c] = 8'h00;
      end
    end
  end

  // RULE8 thresholds default to seven
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      brd_clr_q <= 1'b0;
      done_q <= 1'b0;
      for (int c = 0; c < NCH; c++)
      begin
        alloc_q[c] <= ALLOC_RST;
        tx_alm_q[c] <= ALMOST_RST;
        rx_alm_q[c] <= ALMOST_RST;
        tx_size_q[c] <= CAP_LARGE;
        rx_size_q[c] <= CAP_SMALL;
        tx_data_q[c] <= 8'h00;
      end
    end
    else
    begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      brd_clr_q <= brd_clr_d;
      done_q <= done_d;
      alloc_q <= alloc_d;
      tx_alm_q <= tx_alm_d;
      rx_alm_q <= rx_alm_d;
      tx_size_q <= tx_size_d;
      rx_size_q <= rx_size_d;
      tx_data_q <= tx_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on channel 0 and the bus

  property p_ack_pulse;
    @(posedge core_clk) disable iff (!rst_n)
    (wb_cyc && wb_stb && !ack_q) |=> wb_ack ##1 !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");

  property p_data_write;
    @(posedge core_clk) disable iff (!rst_n)
    (req && wb_we && wb_sel[0] && wb_adr == {3'h0, OFS_DATA} && !tx_pop[0]
      && !tx_clr[0] && tx_flg[0][FLG_FULL]) |=> tx_cnt[0] == $past(tx_cnt[0]) + 16'h0001;
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write did not fill tx"); // RULE1

  property p_fifo_rst;
    @(posedge core_clk) disable iff (!rst_n)
    (req && wr_full && wb_adr == {3'h0, OFS_CSR} && wb_dat_w[CSR_TX_RST]
      && !wb_dat_w[CSR_RX_RST] && wb_dat_w[CSR_ALLOC_LSB +: 2] == alloc_q[0]
      && !brd_clr_q && !rx_push[0]) |=> tx_cnt[0] == 16'h0000 && $stable(rx_cnt[0]);
  endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("tx reset touched rx"); // RULE2

  sequence s_board_clr;
    brd_clr_q;
  endsequence
  property p_board_clr;
    @(posedge core_clk) disable iff (!rst_n)
    s_board_clr |=> tx_alm_q[0] == ALMOST_RST && rx_alm_q[0] == ALMOST_RST
      && tx_cnt[0] == 16'h0000 && !done_q ##1 done_q;
  endproperty
  a_board_clr: assert property (p_board_clr) else $error("board reset incomplete"); // RULE15

  property p_detect;
    @(posedge core_clk) disable iff (!rst_n)
    (!done_q && !brd_clr_q && alloc_d[0] == ALLOC_RST)
      |=> tx_size_q[0] == large_cap(FIFO_OPT) && rx_size_q[0] == small_cap(FIFO_OPT);
  endproperty
  a_detect: assert property (p_detect) else $error("size not detected"); // RULE11

endmodule

// *** serial_engine_model.sv ***
// behavioural serial engine on the far side of the channel fifos
module serial_engine_model
  import chan_fifo_pkg::*;
(
  input wire logic core_clk,
  input wire logic slow,
  input wire logic [NCH-1:0] rx_go,
  input wire logic [NCH-1:0] tx_go,
  output logic [NCH-1:0] tx_pop,
  output logic [NCH-1:0] rx_push,
  output logic [8*NCH-1:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph = 1'b0;
  logic [15:0] seq [NCH];

  initial
  begin
    tx_pop = '0;
    rx_push = '0;
    rx_data = '0;
    for (int c = 0; c < NCH; c++) seq[c] = 16'h0000;
  end

  // one byte per active cycle; slow mode works only every other cycle
  always @(posedge core_clk)
  begin
    ph <= !ph;
    for (int c = 0; c < NCH; c++)
    begin
      if (rx_go[c] && (!slow || ph))
      begin
        rx_push[c] <= 1'b1;
        rx_data[8*c +: 8] <= 8'(seq[c] + 16'(17 * c));
        seq[c] <= seq[c] + 16'h0001;
      end
      else
      begin
        // data not valid: keep it toggling so nothing relies on it
        rx_push[c] <= 1'b0;
        rx_data[8*c +: 8] <= ~rx_data[8*c +: 8];
      end
      // pops even when empty; the fifo must refuse those itself
      tx_pop[c] <= tx_go[c] && (!slow || ph);
    end
  end
endmodule

// *** serial_channel_fifo_manager_test.sv ***
// self-checking bench for the four-channel fifo manager
`define CHK(g, e) chk(32'(g), 32'(e))
module serial_channel_fifo_manager_test
  import chan_fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
  logic wb_ack, slow = 1'b0;
  logic [NCH-1:0] tx_pop, tx_empty_n, rx_push, rx_full_n;
  logic [NCH-1:0] rx_go = '0, tx_go = '0;
  logic [8*NCH-1:0] tx_data, rx_data, irq_src_n;
  logic [63:0] rd_q [$];
  logic [63:0] rd_note;
  logic [7:0] tx_q [NCH][$];
  logic [NCH-1:0] pend = '0;
  int fail_count = 0, n_compared = 0, cycles = 0;
  int tc;
  logic [7:0] b;

  always #5 core_clk = ~core_clk;

  chan_fifo_mgr #(.FIFO_OPT(OPT_4K_8K)) u_chan_fifo_mgr (.core_clk(core_clk), .nrst(nrst),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .tx_pop(tx_pop),
    .tx_data(tx_data), .tx_empty_n(tx_empty_n), .rx_push(rx_push), .rx_data(rx_data),
    .rx_full_n(rx_full_n), .irq_src_n(irq_src_n));

  serial_engine_model u_serial_engine_model (.core_clk(core_clk), .slow(slow), .rx_go(rx_go),
    .tx_go(tx_go), .tx_pop(tx_pop), .rx_push(rx_push), .rx_data(rx_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // classic cycle: hold everything until ack is seen, then release
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= SEL_ALL;
    wb_dat_w <= d;
    do @(posedge core_clk); while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, a, d);
  endtask

  // the expectation is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({m, e & m});
    wb_cycle(1'b0, a, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // read results: oldest note against each read acknowledge
  always @(posedge core_clk)
  begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0)
    begin
      rd_note = rd_q.pop_front();
      `CHK(wb_dat_r & rd_note[63:32], rd_note[31:0]);
    end
  end

  // tx bytes: an accepted pop shows its byte one cycle later
  always @(posedge core_clk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (pend[c])
        `CHK(tx_data[8*c +: 8], tx_q[c].pop_front());
      pend[c] = tx_pop[c] && tx_empty_n[c] === 1'b1;
    end
  end

  // hang guard, far above the few thousand cycles needed
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 30000)
    begin
      fail_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(20));
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    // defaults after reset, every channel
    for (int c = 0; c < NCH; c++)
    begin
      rd(8'(c * 32) + OFS_CSR, 32'h0000_cc00, '1);
      rd(8'(c * 32) + OFS_TX_ALMOST, ALMOST_RST, '1);
      rd(8'(c * 32) + OFS_RX_ALMOST, ALMOST_RST, '1);
      rd(8'(c * 32) + OFS_COUNT, 32'h0, '1);
      rd(8'(c * 32) + OFS_SIZE, {CAP_4K, CAP_8K}, '1);
      rd(8'(c * 32) + 8'h18, 32'h0, '1);
    end
    `CHK(tx_empty_n, 4'h0);
    $display("reset defaults done");
    // almost-empty edge at the eighth byte, then slow drain
    tc = $urandom_range(0, NCH - 1);
    for (int k = 0; k < 8; k++)
    begin
      b = 8'($urandom);
      tx_q[tc].push_back(b);
      wr(8'(tc * 32) + OFS_DATA, {24'h0, b});
      if (k == 6)
        rd(8'(tc * 32) + OFS_CSR, 32'h0000_cd00, 32'h0000_ff00);
    end
    rd(8'(tc * 32) + OFS_CSR, 32'h0000_cf00, 32'h0000_ff00);
    rd(8'(tc * 32) + OFS_COUNT, 32'h8, '1);
    slow <= 1'b1;
    tx_go[tc] <= 1'b1;
    do @(posedge core_clk); while (tx_empty_n[tc] !== 1'b0);
    repeat (3) @(posedge core_clk);
    tx_go[tc] <= 1'b0;
    slow <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(tx_q[tc].size(), 0);
    rd(8'(tc * 32) + OFS_COUNT, 32'h0, '1);
    $display("tx threshold done");
    // rx overfill on channel 2, extra pushes must be dropped
    rx_go[2] <= 1'b1;
    repeat (4099) @(posedge core_clk);
    rx_go[2] <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(rx_full_n[2], 1'b0);
    `CHK(irq_src_n[23:20], 4'h3);
    rd(8'h40 + OFS_COUNT, {16'd4096, 16'd0}, '1);
    rd(8'h40 + OFS_CSR, 32'h0000_3000, 32'h0000_f000);
    for (int k = 0; k < 5; k++)
      rd(8'h40 + OFS_DATA, 32'(8'(k + 34)), '1);
    // count now 4091: almost full turns on exactly at size minus threshold
    wr(8'h40 + OFS_RX_ALMOST, {16'd5, 16'd7});
    rd(8'h40 + OFS_CSR, 32'h0000_b000, 32'h0000_f000);
    wr(8'h40 + OFS_RX_ALMOST, {16'd4, 16'd7});
    rd(8'h40 + OFS_CSR, 32'h0000_f000, 32'h0000_f000);
    $display("rx full and thresholds done");
    // each reset bit empties only its own fifo
    wr(8'h40 + OFS_DATA, 32'h5a);
    wr(8'h40 + OFS_CSR, 32'h2);
    rd(8'h40 + OFS_COUNT, 32'h1, '1);
    rd(8'h40 + OFS_DATA, 32'h0, '1);
    wr(8'h40 + OFS_CSR, 32'h1);
    rd(8'h40 + OFS_COUNT, 32'h0, '1);
    wr({3'h0, OFS_DATA}, 32'ha5);
    rd({3'h0, OFS_COUNT}, 32'h1, '1);
    wr({3'h0, OFS_CSR}, 32'h1);
    rd({3'h0, OFS_COUNT}, 32'h0, '1);
    // rx pushes run on channel 1 while the host pops; bytes must come out in order
    rx_go[1] <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int k = 0; k < 3; k++)
      rd(8'h20 + OFS_DATA, 32'(8'(k + 17)), '1);
    rx_go[1] <= 1'b0;
    wr(8'h20 + OFS_CSR, 32'h2);
    rd(8'h20 + OFS_COUNT, 32'h0, '1);
    $display("fifo resets done");
    // larger memory moved to rx, then board reset restores all
    wr(8'h60 + OFS_CSR, 32'h10);
    rd(8'h60 + OFS_SIZE, {CAP_8K, CAP_4K}, '1);
    wr(BOARD_CTRL_ADR, 32'h1);
    repeat (3) @(posedge core_clk);
    rd(8'h60 + OFS_SIZE, {CAP_4K, CAP_8K}, '1);
    rd(8'h60 + OFS_CSR, 32'h0000_cc00, '1);
    rd(8'h40 + OFS_RX_ALMOST, ALMOST_RST, '1);
    `CHK(tx_data, 32'h0);
    $display("allocation and board reset done");
    repeat (3) @(posedge core_clk);
    `CHK(rd_q.size(), 0);
    test_done();
  end
endmodule
